// ---- hdl/wdc_consts.svh ----
// register map, field codes and timing figures of the watchdog block
// assumes inclusion by the design modules, the host model and the bench
`ifndef WDC_CONSTS_SVH
`define WDC_CONSTS_SVH
// ----------------------------------------
// register addresses, configuration mask and bit positions
// ----------------------------------------
`define WDC_A_CTRL 7'h00
`define WDC_A_STAT 7'h05
`define WDC_A_CFG 7'h74
`define WDC_CFG_MASK 8'h3D
`define WDC_CFG_FNM 3
`define WDC_CFG_SDM 2
`define WDC_CFG_SLP 0
// ----------------------------------------
// operation selection and progress codes
// ----------------------------------------
`define WDC_SEL_AUTO 3'h1
`define WDC_SEL_TOUT 3'h2
`define WDC_SEL_WIN 3'h4
`define WDC_PRG_OFF 2'h0
`define WDC_PRG_FIRST 2'h1
`define WDC_PRG_SECOND 2'h2
// ----------------------------------------
// period codes and lengths in ms
// ----------------------------------------
`define WDC_NWP_8 4'h8
`define WDC_NWP_16 4'h1
`define WDC_NWP_32 4'h2
`define WDC_NWP_64 4'hB
`define WDC_NWP_128 4'h4
`define WDC_NWP_256 4'hD
`define WDC_NWP_1024 4'hE
`define WDC_NWP_4096 4'h7
`define WDC_MS_8 13'h0008
`define WDC_MS_16 13'h0010
`define WDC_MS_32 13'h0020
`define WDC_MS_64 13'h0040
`define WDC_MS_128 13'h0080
`define WDC_MS_256 13'h0100
`define WDC_MS_1024 13'h0400
`define WDC_MS_4096 13'h1000
// ----------------------------------------
// device modes, reset sources, timebase
// ----------------------------------------
`define WDC_M_NORMAL 2'h0
`define WDC_M_STANDBY 2'h1
`define WDC_M_SLEEP 2'h2
`define WDC_RSS_EARLY 5'h0E
`define WDC_RSS_OVF 5'h0F
`define WDC_RSS_ILLEGAL 5'h10
`define WDC_TICK_NS 1000000
`define WDC_CLK_NS 40
`endif

// ---- hdl/wdc_pkg.sv ----
// types shared by the watchdog block
// assumes wdc_consts.svh on the include path
package wdc_pkg;
   typedef enum logic [1:0] {
      WDC_OFF = 2'b00,
      WDC_TOUT = 2'b01,
      WDC_WIN = 2'b10
   } wdc_kind_e;

   typedef struct packed {
      logic [26:0] pre;
      logic [12:0] el;
      logic ovf;
   } wdc_tmr_s;

   typedef struct packed {
      logic nvload;
      logic [7:0] cfg;
      logic [2:0] sel;
      logic [3:0] per;
      logic wd_failure_flag;
      logic rst;
      logic [4:0] src;
      logic wake;
      logic rxdl;
      logic v1on;
      logic stby;
      logic fail;
      logic [7:0] rdata;
      logic nvwr;
      logic [1:0] uvsel;
   } wdc_top_s;
endpackage

// ---- hdl/wdc_tmr_if.sv ----
// carrier between the watchdog control and its period timer
// assumes both ends on mclk
`timescale 1ns/100ps
interface wdc_tmr_if;
   logic run;
   logic restart;
   logic restart_half;
   logic [12:0] period_ms;
   logic second_half;
   logic half_edge;
   logic ovf;
   logic [12:0] elapsed;
   modport ctl (output run, restart, restart_half, period_ms,
                input second_half, half_edge, ovf, elapsed);
   modport tmr (input run, restart, restart_half, period_ms,
                output second_half, half_edge, ovf, elapsed);
endinterface

// ---- hdl/wdc_timer.sv ----
// millisecond period timer of the watchdog
// assumes a single clock mclk and synchronous active-low reset
`timescale 1ns/100ps
`include "wdc_consts.svh"
module wdc_timer
   import wdc_pkg::*;
#(
   parameter int MS_CYCLES = `WDC_TICK_NS / `WDC_CLK_NS
)(
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // control side
   wdc_tmr_if.tmr t
);
   wdc_tmr_s q, d;
   logic [12:0] half;
   logic tick;

   assign half = t.period_ms >> 1;
   assign tick = q.pre == 27'(MS_CYCLES - 1);
   assign t.elapsed = q.el;
   assign t.ovf = q.ovf;
   // boundary is exactly half the period on the same ms count
   assign t.second_half = q.el >= half;
   assign t.half_edge = tick && (q.el + 13'h0001 == half);

   always_comb
   begin
      d = q;
      d.ovf = 1'b0;
      if (!t.run || t.restart)
      begin
         d.pre = '0;
         d.el = '0;
      end
      else if (t.restart_half)
      begin
         d.pre = '0;
         d.el = half;
      end
      else if (tick)
      begin
         d.pre = '0;
         if (q.el + 13'h0001 >= t.period_ms)
         begin
            d.el = '0;
            d.ovf = 1'b1;
         end
         else
            d.el = q.el + 13'h0001;
      end
      else
         d.pre = q.pre + 27'h0000_001;
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         q <= '0;
      else
         q <= d;
   end
endmodule

// ---- hdl/wdc_watchdog.sv ----
// watchdog supervision: configuration, status, window/timeout/autonomous
// assumes decoded register frames and device mode on mclk, nv byte ready
`timescale 1ns/100ps
`include "wdc_consts.svh"
module wdc_watchdog
   import wdc_pkg::*;
#(
   parameter int MS_CYCLES = `WDC_TICK_NS / `WDC_CLK_NS
)(
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // register frames
   input wire logic reg_wr,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_q,
   // device context
   input wire logic [1:0] sbc_mode,
   input wire logic wake_in,
   input wire logic wake_ack,
   input wire logic wdf_clr,
   // non-volatile byte
   input wire logic [7:0] nv_rd_data,
   output logic nv_wr_q,
   output logic [7:0] nv_wr_data_q,
   // results
   output logic sys_reset_q,
   output logic [4:0] reset_source_code_q,
   output logic wd_failure_flag_q,
   output logic wake_event_q,
   output logic rxd_low_q,
   output logic main_regulator_on_q,
   output logic go_standby_q,
   output logic spi_fail_q,
   output logic [1:0] uv_threshold_sel_q,
   output logic sleep_cmd_lock_q,
   output logic forced_normal_flag_q,
   output logic sw_dev_flag_q
);
   wdc_top_s q, d;
   wdc_kind_e kind;
   wdc_tmr_if t ();
   logic forced_normal_ctrl, sw_dev_ctrl, sw_dev_operation;
   logic vsel, vper, wr_ctrl, trig, rs, rh;
   logic [12:0] new_ms;
   logic [1:0] wd_progress;
   logic [7:0] stat_byte;

   function automatic logic [12:0] per_ms(input logic [3:0] c);
      case (c)
         `WDC_NWP_8: per_ms = `WDC_MS_8;
         `WDC_NWP_16: per_ms = `WDC_MS_16;
         `WDC_NWP_32: per_ms = `WDC_MS_32;
         `WDC_NWP_64: per_ms = `WDC_MS_64;
         `WDC_NWP_128: per_ms = `WDC_MS_128;
         `WDC_NWP_256: per_ms = `WDC_MS_256;
         `WDC_NWP_1024: per_ms = `WDC_MS_1024;
         `WDC_NWP_4096: per_ms = `WDC_MS_4096;
         default: per_ms = '0;
      endcase
   endfunction

   wdc_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
      .mclk(mclk),
      .reset_n(reset_n),
      .t(t.tmr)
   );

   // ----------------------------------------
   // configuration decode
   // ----------------------------------------
   assign forced_normal_ctrl = q.cfg[`WDC_CFG_FNM];
   assign sw_dev_ctrl = q.cfg[`WDC_CFG_SDM];
   assign sw_dev_operation = sw_dev_ctrl && !forced_normal_ctrl;
   assign vsel = reg_wdata[7:5] == `WDC_SEL_AUTO ||
                 reg_wdata[7:5] == `WDC_SEL_TOUT ||
                 reg_wdata[7:5] == `WDC_SEL_WIN;
   assign new_ms = per_ms(reg_wdata[3:0]);
   assign vper = new_ms != '0;
   assign wr_ctrl = reg_wr && reg_addr == `WDC_A_CTRL;
   assign wd_progress = kind == WDC_OFF ? `WDC_PRG_OFF :
                        t.second_half ? `WDC_PRG_SECOND :
                        `WDC_PRG_FIRST;
   assign stat_byte = {4'h0, forced_normal_ctrl, sw_dev_operation,
                       wd_progress};

   // ----------------------------------------
   // effective operation per device mode
   // ----------------------------------------
   always_comb
   begin
      kind = WDC_OFF;
      if (forced_normal_ctrl)
         kind = WDC_OFF;
      else
      begin
         case (q.sel)
            `WDC_SEL_WIN:
            begin
               if (sbc_mode == `WDC_M_NORMAL)
                  kind = WDC_WIN;
               else if (sbc_mode != 2'h3)
                  kind = WDC_TOUT;
            end
            `WDC_SEL_TOUT:
            begin
               if (sbc_mode != 2'h3)
                  kind = WDC_TOUT;
            end
            `WDC_SEL_AUTO:
            begin
               if (sw_dev_operation)
                  kind = WDC_OFF;
               else if (sbc_mode == `WDC_M_NORMAL)
                  kind = WDC_TOUT;
               else if (sbc_mode == `WDC_M_STANDBY && q.rxdl)
                  kind = WDC_TOUT;
            end
            default: kind = WDC_OFF;
         endcase
      end
   end

   assign t.run = kind != WDC_OFF;
   assign t.period_ms = per_ms(q.per);
   assign t.restart = rs;
   assign t.restart_half = rh;

   // ----------------------------------------
   // main next-state logic
   // ----------------------------------------
   always_comb
   begin
      d = q;
      d.nvload = 1'b0;
      d.rst = 1'b0;
      d.wake = 1'b0;
      d.stby = 1'b0;
      d.fail = 1'b0;
      d.nvwr = 1'b0;
      trig = 1'b0;
      rs = 1'b0;
      rh = 1'b0;
      if (q.nvload)
      begin
         d.cfg = nv_rd_data & `WDC_CFG_MASK;
         d.uvsel = nv_rd_data[5:4];
         if (nv_rd_data[`WDC_CFG_SDM] && !nv_rd_data[`WDC_CFG_FNM])
            d.sel = `WDC_SEL_AUTO;
      end
      if (reg_wr && reg_addr == `WDC_A_CFG)
      begin
         d.cfg = reg_wdata & `WDC_CFG_MASK;
         d.nvwr = 1'b1;
      end
      if (wr_ctrl)
      begin
         if (!vsel || !vper)
            d.fail = 1'b1;
         else if (sbc_mode == `WDC_M_NORMAL && reg_wdata[7:5] != q.sel)
         begin
            d.rst = 1'b1;
            d.src = `WDC_RSS_ILLEGAL;
         end
         else
         begin
            d.sel = reg_wdata[7:5];
            d.per = reg_wdata[3:0];
            trig = 1'b1;
         end
      end
      if (trig)
      begin
         rs = 1'b1;
         if (kind == WDC_TOUT && t.half_edge)
         begin
            rs = 1'b0;
            rh = 1'b1;
         end
         else if (kind == WDC_TOUT && new_ms < t.period_ms)
         begin
            if (t.second_half)
               d.wd_failure_flag = 1'b1;
            else if (t.elapsed >= (new_ms >> 1))
            begin
               rs = 1'b0;
               rh = 1'b1;
            end
         end
         if (kind == WDC_WIN && !t.second_half)
         begin
            d.rst = 1'b1;
            d.src = `WDC_RSS_EARLY;
         end
      end
      if (t.ovf && kind == WDC_WIN)
      begin
         d.rst = 1'b1;
         d.src = `WDC_RSS_OVF;
      end
      else if (t.ovf && kind == WDC_TOUT)
      begin
         if (q.wd_failure_flag)
         begin
            d.rst = 1'b1;
            d.src = `WDC_RSS_OVF;
         end
         d.wd_failure_flag = 1'b1;
         if (sbc_mode == `WDC_M_SLEEP)
         begin
            d.wake = 1'b1;
            d.rxdl = 1'b1;
            d.v1on = 1'b1;
         end
      end
      else if (wdf_clr && !(trig && d.wd_failure_flag && !q.wd_failure_flag))
         d.wd_failure_flag = 1'b0;
      if (wake_in && q.sel == `WDC_SEL_AUTO && !sw_dev_operation &&
          !forced_normal_ctrl)
      begin
         d.rxdl = 1'b1;
         rs = 1'b1;
         if (sbc_mode == `WDC_M_SLEEP)
            d.stby = 1'b1;
      end
      else if (wake_ack && !d.wake)
         d.rxdl = 1'b0;
      if (sbc_mode != `WDC_M_SLEEP)
         d.v1on = 1'b0;
      case (reg_addr)
         `WDC_A_CTRL: d.rdata = {q.sel, 1'b0, q.per};
         `WDC_A_STAT: d.rdata = stat_byte;
         `WDC_A_CFG: d.rdata = q.cfg;
         default: d.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         q <= '{nvload: 1'b1, sel: `WDC_SEL_TOUT, per: `WDC_NWP_128,
                default: '0};
      else
         q <= d;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign reg_rdata_q = q.rdata;
   assign nv_wr_q = q.nvwr;
   assign nv_wr_data_q = q.cfg;
   assign sys_reset_q = q.rst;
   assign reset_source_code_q = q.src;
   assign wd_failure_flag_q = q.wd_failure_flag;
   assign wake_event_q = q.wake;
   assign rxd_low_q = q.rxdl;
   assign main_regulator_on_q = q.v1on;
   assign go_standby_q = q.stby;
   assign spi_fail_q = q.fail;
   assign uv_threshold_sel_q = q.uvsel;
   assign sleep_cmd_lock_q = q.cfg[`WDC_CFG_SLP];
   assign forced_normal_flag_q = q.cfg[`WDC_CFG_FNM];
   assign sw_dev_flag_q = q.cfg[`WDC_CFG_SDM] && !q.cfg[`WDC_CFG_FNM];

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   a_uv_startup_load: assert property (
      q.nvload |=> uv_threshold_sel_q == $past(nv_rd_data[5:4]))
      else $error("start-up threshold not loaded");
   a_fnm_wd_off: assert property (
      forced_normal_ctrl |-> !t.run)
      else $error("watchdog runs in forced normal");
   a_fnm_over_sdm: assert property (
      forced_normal_flag_q |-> !sw_dev_flag_q)
      else $error("sw development flag under forced normal");
   a_sdm_auto_start: assert property (
      q.nvload && nv_rd_data[2] && !nv_rd_data[3]
      |=> q.sel == `WDC_SEL_AUTO ##1 !t.run)
      else $error("sw development start not autonomous off");
   a_win_early_rst: assert property (
      wr_ctrl && vsel && vper && kind == WDC_WIN && !t.second_half &&
      reg_wdata[7:5] == q.sel
      |=> sys_reset_q && reset_source_code_q == `WDC_RSS_EARLY)
      else $error("early window trigger without reset");
   a_tout_second_ovf: assert property (
      t.ovf && kind == WDC_TOUT && q.wd_failure_flag
      |=> sys_reset_q && reset_source_code_q == `WDC_RSS_OVF)
      else $error("pending failure overflow without reset");
   a_sleep_wake_seq: assert property (
      t.ovf && kind == WDC_TOUT && sbc_mode == `WDC_M_SLEEP
      |=> wake_event_q && rxd_low_q && wd_failure_flag_q ##1 !wake_event_q)
      else $error("sleep overflow wake sequence wrong");
   a_illegal_sel: assert property (
      wr_ctrl && vsel && vper && sbc_mode == `WDC_M_NORMAL &&
      reg_wdata[7:5] != q.sel
      |=> sys_reset_q && reset_source_code_q == `WDC_RSS_ILLEGAL &&
          $stable(q.sel))
      else $error("illegal selection change not caught");
   a_bad_code_abort: assert property (
      wr_ctrl && !(vsel && vper) |=> spi_fail_q && $stable(q.per))
      else $error("invalid code not refused");

   c_window_restart: cover property (
      wr_ctrl && kind == WDC_WIN && t.second_half);
   c_tout_flag: cover property (t.ovf && kind == WDC_TOUT && !q.wd_failure_flag);
   c_auto_wake: cover property (wake_in && q.sel == `WDC_SEL_AUTO);
endmodule

// ---- verif/wdc_host.sv ----
// host model: issues decoded register frames to the watchdog block
// assumes mclk from the bench; frames change on the falling edge only
`timescale 1ns/100ps
`include "wdc_consts.svh"
module wdc_host (
   // clock
   input wire logic mclk,
   // register frames
   output logic reg_wr,
   output logic [6:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_q
);
   initial
   begin
      reg_wr = 1'b0;
      reg_addr = 7'h7F;
      reg_wdata = 8'h00;
   end

   // one write frame, taken at the next rising edge
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_addr = 7'h7F;
      reg_wdata = ~d;
   endtask

   // read: address held over one edge, registered data sampled after it
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      @(negedge mclk);
      d = reg_rdata_q;
      reg_addr = 7'h7F;
   endtask

   // period change or trigger: the same code twice, back to back
   task automatic wr_twice(input logic [7:0] d);
      wr(`WDC_A_CTRL, d);
      wr(`WDC_A_CTRL, d);
   endtask
endmodule

// ---- verif/test_sbc_watchdog_config_status.sv ----
// bench for the watchdog block: config, status and watchdog behaviour
// assumes the design files and wdc_consts.svh on the include path
`timescale 1ns/100ps
`include "wdc_consts.svh"
module test_sbc_watchdog_config_status;
   import wdc_pkg::*;
   logic mclk, reset_n, reg_wr, wake_in, wake_ack, wdf_clr;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata_q, nv_rd_data, nv_wr_data_q;
   logic [1:0] sbc_mode, uv_sel;
   logic nv_wr_q, sys_reset_q, wd_failure_flag, wake_ev, rxd_low, reg_on, go_stby;
   logic spi_fail, slp_lock, fnm_flag, sdm_flag;
   logic [4:0] src;
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   int n_rst = 0;
   int n_spi = 0;
   int n_wake = 0;
   int n_stby = 0;
   int i, b;

   // ----------------------------------------
   // design and host
   // ----------------------------------------
   wdc_watchdog #(.MS_CYCLES(4)) i_wdc_watchdog (
      .mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata_q(reg_rdata_q), .sbc_mode(sbc_mode), .wake_in(wake_in),
      .wake_ack(wake_ack), .wdf_clr(wdf_clr), .nv_rd_data(nv_rd_data),
      .nv_wr_q(nv_wr_q), .nv_wr_data_q(nv_wr_data_q),
      .sys_reset_q(sys_reset_q), .reset_source_code_q(src),
      .wd_failure_flag_q(wd_failure_flag), .wake_event_q(wake_ev),
      .rxd_low_q(rxd_low), .main_regulator_on_q(reg_on),
      .go_standby_q(go_stby), .spi_fail_q(spi_fail),
      .uv_threshold_sel_q(uv_sel), .sleep_cmd_lock_q(slp_lock),
      .forced_normal_flag_q(fnm_flag), .sw_dev_flag_q(sdm_flag));
   wdc_host host (.mclk(mclk), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // pulse counters and hang guard
   always @(posedge mclk)
   begin
      cyc++;
      if (sys_reset_q === 1'b1)
         n_rst++;
      if (spi_fail === 1'b1)
         n_spi++;
      if (wake_ev === 1'b1)
         n_wake++;
      if (go_stby === 1'b1)
         n_stby++;
      if (cyc == 6000)
      begin
         err_total++;
         print_verdict();
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string m);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic rchk(input logic [6:0] a, input logic [7:0] e,
                       input string m);
      logic [7:0] d;
      host.rd(a, d);
      chk(d, e, m);
   endtask

   task automatic rst(input logic [7:0] nv);
      @(negedge mclk);
      reset_n = 1'b0;
      nv_rd_data = nv;
      sbc_mode = `WDC_M_STANDBY;
      repeat (10) @(negedge mclk);
      reset_n = 1'b1;
      repeat (2) @(negedge mclk);
   endtask

   task automatic print_verdict();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_config();
      rst(8'h35);
      chk({6'h00, uv_sel}, 8'h03, "uv sel");
      chk({7'h00, slp_lock}, 8'h01, "sleep lock");
      chk({7'h00, sdm_flag}, 8'h01, "sdm flag");
      rchk(`WDC_A_CFG, 8'h35, "cfg read");
      rchk(`WDC_A_STAT, 8'h04, "sdm autonomous off");
      host.wr(`WDC_A_CTRL, 8'h44);
      rchk(`WDC_A_STAT, 8'h05, "sdm timeout on");
      b = n_stby;
      host.wr(`WDC_A_CFG, 8'hFF);
      chk({7'h00, nv_wr_q}, 8'h01, "nv store pulse");
      rchk(`WDC_A_CFG, 8'h3D, "cfg reserved bits");
      chk(nv_wr_data_q, 8'h3D, "nv byte");
      host.wr(`WDC_A_STAT, 8'hF0);
      rchk(7'h33, 8'h00, "unmapped read");
      rst(8'h0C);
      rchk(`WDC_A_STAT, 8'h08, "forced overrules sdm");
      chk({6'h00, fnm_flag, sdm_flag}, 8'h02, "forced flags");
      host.wr(`WDC_A_CTRL, 8'h44);
      rchk(`WDC_A_STAT, 8'h08, "forced keeps off");
   endtask

   task automatic t_timeout();
      rst(8'h00);
      host.wr(`WDC_A_CTRL, 8'h44);
      rchk(`WDC_A_STAT, 8'h01, "restart first half");
      repeat (240) @(negedge mclk);
      rchk(`WDC_A_STAT, 8'h01, "before half");
      repeat (30) @(negedge mclk);
      rchk(`WDC_A_STAT, 8'h02, "after half");
      b = n_rst;
      for (i = 0; i < 300 && wd_failure_flag !== 1'b1; i++)
         @(negedge mclk);
      chk({7'h00, wd_failure_flag}, 8'h01, "overflow flag");
      chk(n_rst - b, 0, "no reset on first overflow");
      for (i = 0; i < 600 && n_rst == b; i++)
         @(negedge mclk);
      chk(n_rst - b, 1, "second overflow reset");
      chk({3'h0, src}, {3'h0, `WDC_RSS_OVF}, "overflow source");
   endtask

   task automatic t_window();
      rst(8'h00);
      host.wr(`WDC_A_CTRL, 8'h84);
      sbc_mode = `WDC_M_NORMAL;
      b = n_rst;
      repeat (300) @(negedge mclk);
      host.wr(`WDC_A_CTRL, 8'h84);
      chk(n_rst - b, 0, "late trigger accepted");
      rchk(`WDC_A_STAT, 8'h01, "window restart");
      host.wr(`WDC_A_CTRL, 8'h84);
      @(negedge mclk);
      chk(n_rst - b, 1, "early trigger reset");
      chk({3'h0, src}, {3'h0, `WDC_RSS_EARLY}, "early source");
      host.wr(`WDC_A_CTRL, 8'h44);
      @(negedge mclk);
      chk(n_rst - b, 2, "change in normal");
      chk({3'h0, src}, {3'h0, `WDC_RSS_ILLEGAL}, "illegal source");
      b = n_spi;
      host.wr(`WDC_A_CTRL, 8'h64);
      host.wr(`WDC_A_CTRL, 8'h89);
      @(negedge mclk);
      chk(n_spi - b, 2, "invalid codes refused");
   endtask

   task automatic t_periods();
      logic [3:0] codes [8];
      codes = '{4'h8, 4'h1, 4'h2, 4'hB, 4'h4, 4'hD, 4'hE, 4'h7};
      rst(8'h00);
      rchk(`WDC_A_CTRL, 8'h44, "control default");
      b = n_spi;
      for (int k = 0; k < 8; k++)
      begin
         host.wr(`WDC_A_CTRL, {4'h4, codes[k]});
         rchk(`WDC_A_CTRL, {4'h4, codes[k]}, "period code");
      end
      chk(n_spi - b, 0, "valid codes kept");
      host.wr_twice(8'h48);
      wdf_clr = 1'b1;
      @(negedge mclk);
      wdf_clr = 1'b0;
      rchk(`WDC_A_STAT, 8'h01, "short period rewrite");
   endtask

   task automatic t_sleep();
      rst(8'h00);
      sbc_mode = `WDC_M_SLEEP;
      host.wr(`WDC_A_CTRL, 8'h48);
      b = n_wake;
      for (i = 0; i < 60 && n_wake == b; i++)
         @(negedge mclk);
      chk(n_wake - b, 1, "sleep wake");
      chk({5'h0, rxd_low, reg_on, wd_failure_flag}, 8'h07, "rxd reg flag");
      wdf_clr = 1'b1;
      wake_ack = 1'b1;
      @(negedge mclk);
      wdf_clr = 1'b0;
      wake_ack = 1'b0;
      @(negedge mclk);
      chk({6'h0, rxd_low, wd_failure_flag}, 8'h00, "ack and clear");
   endtask

   task automatic t_auto();
      rst(8'h00);
      host.wr(`WDC_A_CTRL, 8'h24);
      rchk(`WDC_A_STAT, 8'h00, "auto standby off");
      sbc_mode = `WDC_M_SLEEP;
      repeat (20) @(negedge mclk);
      rchk(`WDC_A_STAT, 8'h00, "auto sleep off");
      b = n_stby;
      wake_in = 1'b1;
      @(negedge mclk);
      wake_in = 1'b0;
      for (i = 0; i < 5 && n_stby == b; i++)
         @(negedge mclk);
      chk(n_stby - b, 1, "sleep to standby");
      chk({7'h0, rxd_low}, 8'h01, "rxd forced low");
      sbc_mode = `WDC_M_STANDBY;
      rchk(`WDC_A_STAT, 8'h01, "auto restarted");
   endtask

   initial
   begin
      reset_n = 1'b0;
      sbc_mode = `WDC_M_STANDBY;
      wake_in = 1'b0;
      wake_ack = 1'b0;
      wdf_clr = 1'b0;
      nv_rd_data = 8'h00;
      t_config();
      t_timeout();
      t_window();
      t_periods();
      t_sleep();
      t_auto();
      print_verdict();
   end
endmodule
